// *** src/sbit_timer.sv ***
// Purpose: Sixteen-bit up-counting interval timer with AHB-Lite register slave
// Assumes: Inputs synchronous to sys_clk; prescaler tick is a one-cycle enable
// Notes: Zero-wait-state slave, response always OKAY
//
// Functional notes
// - Debug freeze bit 1 suspends counting during debug halt; 0 keeps counting.
// - Idle-run bit 0 suspends counting in idle; 1 keeps counting.
// - Counter increments on each selected source tick while count-go is 1.
// - On compare match the count returns to zero and keeps counting.
// - Each compare match emits a match interrupt pulse.
// - Clearing count-go stops counting and holds the count.
// - Software clears counter by writing zero to snapshot; device loads zero.
// - Snapshot read returns live count in bits 15:0, upper bits zero.
// - Sixteen-bit read-write compare value; software never programs zero.
// - Source select 0 picks system clock, 1 picks prescaler tick.
// - Toggle enable bit 7 inverts square wave on every match that meets no same-cycle forcing write.
// - Output-control writes: 00 invert, 01 set, 10 clear, 11 nothing; reads 11.
// - Square wave is low after reset.
// - Square wave changes only on output-control writes while counter is stopped.
// - Counting resumes automatically when idle mode ends.
// - Counting resumes automatically when debug halt is released.
module sbit_timer
  import sbit_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System status
  input wire logic prescaleTick,
  input wire logic idleMode,
  input wire logic debugHalt,
  // Timer outputs
  output logic squareWaveOut,
  output logic matchInterrupt,
  output logic irqOut
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sbit_state_t state_r;
  sbit_state_t state_nxt;

  logic wrEn;
  logic countEn;
  logic srcTick;
  logic isMatch;
  logic [1:0] forceCode;
  logic [31:0] rdMux;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.matchPulse = 1'b0;
    wrEn = (state_r.phase == SBIT_DATA) && state_r.req.sel && state_r.req.write;
    srcTick = state_r.srcSel ? prescaleTick : 1'b1;
    // Suspension is a live gate, so leaving idle or halt resumes by itself
    countEn = state_r.countGo && srcTick
      && !(idleMode && !state_r.idleKeep)
      && !(debugHalt && state_r.dbgFreeze);
    isMatch = countEn && (state_r.count == state_r.compare);
    forceCode = FORCE_NOP;

    // Counter
    if (countEn) begin
      if (isMatch) begin
        state_nxt.count = CNT_ZERO;
        state_nxt.matchPulse = 1'b1;
        if (state_r.toggleEn) begin
          state_nxt.squareWave = ~state_r.squareWave;
        end
      end else begin
        state_nxt.count = state_r.count + CNT_ONE;
      end
    end

    // Register writes take effect in the data phase
    if (wrEn) begin
      case (state_r.req.addr)
        OFF_POWER_MODE: begin
          state_nxt.idleKeep = hwdata[BIT_IDLE_KEEP];
          state_nxt.dbgFreeze = hwdata[BIT_DBG_FREEZE];
        end
        OFF_RUN_CTRL: begin
          state_nxt.countGo = hwdata[BIT_COUNT_GO];
        end
        OFF_TIMER_CTRL: begin
          state_nxt.srcSel = hwdata[BIT_SRC_SEL];
          state_nxt.toggleEn = hwdata[BIT_TOGGLE_EN];
          forceCode = hwdata[BIT_FORCE_HI:BIT_FORCE_LO];
          // Bit 15 is write-zero only and never stored
        end
        OFF_COMPARE: begin
          state_nxt.compare = hwdata[15:0];
        end
        OFF_SNAPSHOT: begin
          // Any write loads zero; software is expected to write zero
          state_nxt.count = CNT_ZERO;
        end
        OFF_IRQ_MASK: begin
          state_nxt.irqMask = hwdata[BIT_MATCH_IRQ];
        end
        OFF_IRQ_STATUS: begin
          if (hwdata[BIT_MATCH_IRQ]) begin
            state_nxt.irqStatus = 1'b0;
          end
        end
        default: begin
          state_nxt.irqMask = state_r.irqMask;
        end
      endcase
    end

    // Software forcing wins over a same-cycle match toggle
    case (forceCode)
      FORCE_INVERT: state_nxt.squareWave = ~state_r.squareWave;
      FORCE_SET: state_nxt.squareWave = 1'b1;
      FORCE_CLEAR: state_nxt.squareWave = 1'b0;
      default: state_nxt.squareWave = state_nxt.squareWave;
    endcase

    // Set wins over clear on the sticky status bit
    if (isMatch) begin
      state_nxt.irqStatus = 1'b1;
    end
    state_nxt.irq = state_nxt.irqStatus && state_nxt.irqMask;

    // Read mux, reserved bits zero
    rdMux = WORD_ZERO;
    case (hsel && htrans == HTRANS_NONSEQ && !hwrite ? haddr[7:0] : OFF_IRQ_MASK ^ OFF_IRQ_MASK)
      OFF_POWER_MODE: begin
        rdMux[BIT_IDLE_KEEP] = state_nxt.idleKeep;
        rdMux[BIT_DBG_FREEZE] = state_nxt.dbgFreeze;
      end
      OFF_RUN_CTRL: rdMux[BIT_COUNT_GO] = state_nxt.countGo;
      OFF_TIMER_CTRL: begin
        rdMux[BIT_SRC_SEL] = state_nxt.srcSel;
        rdMux[BIT_TOGGLE_EN] = state_nxt.toggleEn;
        rdMux[BIT_FORCE_HI:BIT_FORCE_LO] = FORCE_NOP;
      end
      OFF_COMPARE: rdMux[15:0] = state_nxt.compare;
      OFF_SNAPSHOT: rdMux[15:0] = state_nxt.count;
      OFF_IRQ_STATUS: rdMux[BIT_MATCH_IRQ] = state_nxt.irqStatus;
      OFF_IRQ_MASK: rdMux[BIT_MATCH_IRQ] = state_nxt.irqMask;
      default: rdMux = WORD_ZERO;
    endcase
    // Power-mode offset is zero, so an idle read mux would show it; gate it
    if (!(hsel && htrans == HTRANS_NONSEQ && !hwrite && hready)) begin
      rdMux = state_r.rdata;
    end
    state_nxt.rdata = rdMux;

    // Address phase capture
    if (hready) begin
      state_nxt.req.sel = hsel && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
      state_nxt.req.write = hwrite;
      state_nxt.req.addr = haddr[7:0];
      state_nxt.phase = (hsel && htrans == HTRANS_NONSEQ) ? SBIT_DATA : SBIT_ADDR;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= '{phase: SBIT_ADDR, req: '0, rdata: WORD_ZERO, idleKeep: 1'b0, dbgFreeze: 1'b0,
                   countGo: 1'b0, srcSel: 1'b0, toggleEn: 1'b0, compare: CMP_RESET, count: CNT_ZERO,
                   squareWave: 1'b0, irqStatus: 1'b0, irqMask: 1'b0, irq: 1'b0,
                   matchPulse: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    hrdata = state_r.rdata;
    hreadyout = 1'b1;
    hresp = 1'b0;
    squareWaveOut = state_r.squareWave;
    matchInterrupt = state_r.matchPulse;
    irqOut = state_r.irq;
  end
endmodule

// *** shared/sbit_pkg.sv ***
// Purpose: Constants and types for the sixteen-bit interval timer
// Assumes: AHB-Lite slave, 32-bit data, one clock
// Notes: Offsets are byte addresses
package sbit_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFF_POWER_MODE = 8'h00;
  localparam logic [7:0] OFF_RUN_CTRL = 8'h04;
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h08;
  localparam logic [7:0] OFF_COMPARE = 8'h0c;
  localparam logic [7:0] OFF_SNAPSHOT = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int BIT_IDLE_KEEP = 0;
  localparam int BIT_DBG_FREEZE = 1;
  localparam int BIT_COUNT_GO = 0;
  localparam int BIT_SRC_SEL = 0;
  localparam int BIT_FORCE_LO = 4;
  localparam int BIT_FORCE_HI = 5;
  localparam int BIT_TOGGLE_EN = 7;
  localparam int BIT_CTRL_W0 = 15;
  localparam int BIT_MATCH_IRQ = 0;
  localparam logic [1:0] FORCE_INVERT = 2'h0;
  localparam logic [1:0] FORCE_SET = 2'h1;
  localparam logic [1:0] FORCE_CLEAR = 2'h2;
  localparam logic [1:0] FORCE_NOP = 2'h3;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CMP_RESET = 16'h0000;

  // ----------------------------------------
  // Bus constants
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [0:0] {
    SBIT_ADDR = 1'b0,
    SBIT_DATA = 1'b1
  } sbit_phase_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } sbit_req_t;

  typedef struct packed {
    sbit_phase_t phase;
    sbit_req_t req;
    logic [31:0] rdata;
    logic idleKeep;
    logic dbgFreeze;
    logic countGo;
    logic srcSel;
    logic toggleEn;
    logic [15:0] compare;
    logic [15:0] count;
    logic squareWave;
    logic irqStatus;
    logic irqMask;
    logic irq;
    logic matchPulse;
  } sbit_state_t;
endpackage

// *** tb/sbit_timer_properties.sv ***
// Purpose: Port properties of the interval timer
// Assumes: Zero-wait slave, read data in the data phase
// Notes: Wave changes only after a match or a write
module sbit_timer_properties
  import sbit_pkg::*;
(
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Timer outputs
  input wire logic squareWaveOut,
  input wire logic matchInterrupt,
  input wire logic irqOut
);
  logic [9:0] phR;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) phR <= 10'h000;
    else phR <= {hsel && hready && htrans == HTRANS_NONSEQ, hwrite, haddr[7:0]};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall");
  a_snap_upper: assert property (phR == {2'h2, OFF_SNAPSHOT} |-> hrdata[31:16] == 16'h0)
    else $error("snapshot upper");
  a_ctrl_fixed: assert property (phR == {2'h2, OFF_TIMER_CTRL} |-> (hrdata & 32'hffff_ff7e) == 32'h30)
    else $error("control readback");
  a_power_rsvd: assert property (phR == {2'h2, OFF_POWER_MODE} |-> hrdata[31:2] == 30'h0)
    else $error("power reserved");
  a_unmapped_zero: assert property (phR == 10'h21c |-> hrdata == 32'h0) else $error("unmapped");
  a_pulse_single: assert property (matchInterrupt |=> !matchInterrupt) else $error("pulse");
  a_wave_cause: assert property ($changed(squareWaveOut) |-> matchInterrupt || $past(matchInterrupt)
    || $past(phR[9] && phR[8])) else $error("wave moved");
  a_reset_quiet: assert property (disable iff (1'h0) !nrst |-> !squareWaveOut && !matchInterrupt && !irqOut)
    else $error("reset outputs");
endmodule
bind sbit_timer sbit_timer_properties u_sbit_timer_properties (.*);

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the interval timer
// Assumes: Zero-wait slave; inputs change after rising edges
// Notes: Match spacing is counted in ticks the bench expects
module tb
  import sbit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, nrst, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
  logic prescaleTick = 1'h0, idleMode = 1'h0, debugHalt = 1'h0, squareWaveOut, matchInterrupt, irqOut;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, c, s;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic src = 1'h0, ik = 1'h0, df = 1'h0, te = 1'h0, w;
  int fails = 0, cmp_count = 0, cnt = 0, gap = 0, np = 0, i;
  // Suspended cycles are not ticks, so the spacing stays fixed
  wire tk = (src ? prescaleTick : 1'h1) && !(idleMode && !ik) && !(debugHalt && df);
  assign hready = hreadyout;
  always #10 sys_clk = ~sys_clk;
  sbit_timer u_sbit_timer (.*);
  always @(posedge sys_clk) begin
    prescaleTick <= 1'($urandom % 2);
    idleMode <= ($urandom % 4) == 0;
    debugHalt <= ($urandom % 4) == 0;
    cnt <= (matchInterrupt === 1'h1) ? int'(tk) : cnt + int'(tk);
    if (matchInterrupt === 1'h1) begin
      gap <= cnt;
      np <= np + 1;
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    fails += int'(g !== e);
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
  endtask
  task automatic wt(input int tgt);
    int k;
    for (k = 0; k < 3000 && (k == 0 || np < tgt || hreadyout !== 1'h1); k++) @(posedge sys_clk);
    fails += int'(k == 3000);
    if (k == 3000) summarize();
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {hsel, hwrite, htrans, haddr} <= {1'h1, wr, HTRANS_NONSEQ, 24'h0, a};
    wt(0);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
    wt(0);
    q = hrdata;
  endtask
  function automatic logic fx(logic v, int f);
    return f == 0 ? !v : f == 3 ? v : f == 1;
  endfunction
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    // Driven nonblocking at time zero so the asynchronous reset sees a real falling edge
    nrst <= 1'h0;
    void'($urandom(72));
    repeat (5) @(posedge sys_clk);
    nrst <= 1'h1;
    for (i = 0; i < 8; i++) begin
      xfer(1'h0, 8'(4 * i), 32'h0);
      chk("reset", (i == 2) ? 32'h30 : 32'h0, q);
    end
    chk("wave reset", 32'h0, {31'h0, squareWaveOut});
    for (i = 0; i < 16; i++) begin
      {te, df, ik, src} = 4'(i);
      c = (i == 0) ? 32'h1 : 32'(1 + $urandom % 8);
      xfer(1'h1, OFF_POWER_MODE, {30'h0, df, ik});
      xfer(1'h1, OFF_TIMER_CTRL, {24'h0, te, 3'h3, 3'h0, src});
      xfer(1'h1, OFF_IRQ_MASK, 32'(i % 2));
      xfer(1'h1, OFF_COMPARE, c);
      xfer(1'h0, OFF_COMPARE, 32'h0);
      chk("compare", c, q);
      xfer(1'h1, OFF_SNAPSHOT, 32'h0);
      xfer(1'h0, OFF_SNAPSHOT, 32'h0);
      chk("clear", 32'h0, q);
      xfer(1'h1, OFF_RUN_CTRL, 32'h1);
      wt(np + 1);
      w = squareWaveOut;
      wt(np + 1);
      chk("gap", c + 1, 32'(gap));
      chk("toggle", {31'h0, te ^ w}, {31'h0, squareWaveOut});
      xfer(1'h0, OFF_SNAPSHOT, 32'h0);
      chk("live", 32'h1, 32'(q <= c));
      xfer(1'h1, OFF_RUN_CTRL, 32'h0);
      xfer(1'h0, OFF_SNAPSHOT, 32'h0);
      s = q;
      w = squareWaveOut;
      repeat (9) @(posedge sys_clk);
      xfer(1'h0, OFF_SNAPSHOT, 32'h0);
      chk("held", s, q);
      chk("wave hold", {31'h0, w}, {31'h0, squareWaveOut});
      chk("irq", 32'(i % 2), {31'h0, irqOut});
      xfer(1'h0, OFF_IRQ_STATUS, 32'h0);
      chk("status", 32'h1, q);
      xfer(1'h1, OFF_IRQ_STATUS, 32'h1);
      xfer(1'h0, OFF_IRQ_STATUS, 32'h0);
      chk("status clear", 32'h0, q);
      chk("irq clear", 32'h0, {31'h0, irqOut});
    end
    for (i = 0; i < 4; i++) begin
      w = squareWaveOut;
      xfer(1'h1, OFF_TIMER_CTRL, {16'h0, 1'h1, 9'h0, 2'(i), 4'h0});
      @(posedge sys_clk);
      chk("force", {31'h0, fx(w, i)}, {31'h0, squareWaveOut});
    end
    xfer(1'h0, OFF_TIMER_CTRL, 32'h0);
    chk("control", 32'h30, q);
    summarize();
  end
endmodule
